/* File: core/ffc_fifo_top.v */
// Flagged FIFO core: storage, standard and fall-through timing, status flags
// Overview of operation
// - Almost-full changes only on write-clock edges
// - Almost-full deasserts one cycle after freeing read
// - Almost-empty deasserts one cycle after filling write
// - Standard mode depth equals memory size
// - Fall-through depth is memory size plus one
// - Chain outputs feed next inputs directly
// - Valid output word drives output-ready low
// - Free location drives input-ready low
// - Full chain input-ready latency bound
// - Ripple latency only for first word
// - Output-ready low with first valid word
`timescale 1ns/1ns
`default_nettype none
`include "ffc_fifo_regs.vh"

module ffc_fifo_top #(
	parameter WIDTH = `FFC_DATA_WIDTH,
	parameter AW    = `FFC_ADDR_WIDTH
) (
	// Clock, reset and freeze
	input  wire             mclk,
	input  wire             rst_n,
	input  wire             ce,
	// Master reset and timing-mode select sampled during it
	input  wire             masterReset_n,
	input  wire             fallThroughSel,
	// Flag offsets, in words
	input  wire [AW:0]      fullOffset,
	input  wire [AW:0]      emptyOffset,
	// Write side
	input  wire             wrEn_n,
	input  wire [WIDTH-1:0] dataIn,
	// Read side
	input  wire             rdEn_n,
	output wire [WIDTH-1:0] dataOut,
	// Standard-mode flags
	output reg              empty_n_ff,
	output reg              full_n_ff,
	// Fall-through-mode flags
	output reg              outputReady_n_ff,
	output reg              inputReady_n_ff,
	// Programmable and half flags
	output reg              almostFull_n_ff,
	output reg              almostEmpty_n_ff,
	output reg              halfFull_n_ff,
	// Latched timing mode
	output reg              fallThroughMode_ff
);

	// Count width: holds memory size plus the output word
	localparam CW       = AW + 2;
	localparam [CW-1:0] MEM_DEPTH = {{(CW-AW-1){1'b0}}, 1'b1, {AW{1'b0}}};
	// Extra stage word, cut to the count width on purpose
	localparam integer  FT_EXTRA_I = `FFC_FT_EXTRA_WORDS;
	localparam [CW-1:0] FT_EXTRA   = FT_EXTRA_I[CW-1:0];

	////////////////////////////////////////////////////////////////////////////
	// Helper functions

	// Maximum depth used for thresholds in a given mode
	function [CW-1:0] maxDepth;
		input ftMode;
		begin
			if (ftMode) begin
				maxDepth = MEM_DEPTH + FT_EXTRA;
			end else begin
				maxDepth = MEM_DEPTH;
			end
		end
	endfunction

	// Widen an offset to the count width
	function [CW-1:0] widen;
		input [AW:0] val;
		begin
			widen = {1'b0, val};
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// State

	reg  [AW-1:0]    wrPtr_ff;       // Next write location
	reg  [AW-1:0]    rdPtr_ff;       // Next read location
	reg  [CW-1:0]    memCnt_ff;      // Words held in the array
	reg  [WIDTH-1:0] stdData_ff;     // Standard-mode output word
	wire [WIDTH-1:0] memRdData;      // Array word at the read pointer
	wire [WIDTH-1:0] ftData;         // Fall-through stage word
	wire             ftValid;        // Fall-through stage holds a word

	// Operation decode
	wire mrst     = !masterReset_n;
	wire memFull  = (memCnt_ff == MEM_DEPTH);
	wire memEmpty = (memCnt_ff == {CW{1'b0}});
	// Write accepted only with room in the array
	wire wrOk     = !wrEn_n && !memFull && !mrst;
	// Fall-through read consumes the held word
	wire ftRead   = fallThroughMode_ff && !rdEn_n && ftValid && !mrst;
	// Stage refills whenever the array holds a word and the stage is empty or being read; no read request needed
	wire ftPop    = fallThroughMode_ff && !memEmpty && (!ftValid || ftRead) && !mrst;
	// Standard read needs a word in the array; reads when empty are ignored
	wire stdPop   = !fallThroughMode_ff && !rdEn_n && !memEmpty && !mrst;
	wire pop      = ftPop || stdPop;

	// Next counts
	reg  [CW-1:0] nxt_memCnt;
	reg           nxt_ftValid;
	reg  [CW-1:0] nxt_total;
	reg           nxt_ftMode;

	// Next flags
	reg nxt_empty_n;
	reg nxt_full_n;
	reg nxt_outputReady_n;
	reg nxt_inputReady_n;
	reg nxt_almostFull_n;
	reg nxt_almostEmpty_n;
	reg nxt_halfFull_n;

	////////////////////////////////////////////////////////////////////////////
	// Storage and fall-through stage

	ffc_store #(
		.WIDTH (WIDTH),
		.AW    (AW)
	) uStore (
		.mclk     (mclk),
		.ce       (ce),
		.wrStrobe (wrOk),
		.wrAddr   (wrPtr_ff),
		.wrData   (dataIn),
		.rdAddr   (rdPtr_ff),
		.rdData   (memRdData)
	);

	// The held word is the chain's data output; it feeds the next device as is
	ffc_out_stage #(
		.WIDTH (WIDTH)
	) uOutStage (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.ce       (ce),
		.clear    (mrst),
		.load     (ftPop),
		.consume  (ftRead),
		.loadData (memRdData),
		.data_ff  (ftData),
		.valid_ff (ftValid)
	);

	// Output mux, both sources are flip-flops
	assign dataOut = fallThroughMode_ff ? ftData : stdData_ff;

	////////////////////////////////////////////////////////////////////////////
	// Next-state counts and flags
	// Flags are built from next counts and registered, so an operation on
	// edge k shows on the flag right after edge k, since both sides share one clock;
	// output ready for a write into an empty fall-through buffer shows after edge k+1.
	always @* begin
		nxt_ftMode = mrst ? fallThroughSel : fallThroughMode_ff;
		nxt_memCnt = memCnt_ff;
		if (mrst) begin
			nxt_memCnt = {CW{1'b0}};
		end else if (wrOk && !pop) begin
			nxt_memCnt = memCnt_ff + {{(CW-1){1'b0}}, 1'b1};
		end else if (!wrOk && pop) begin
			nxt_memCnt = memCnt_ff - {{(CW-1){1'b0}}, 1'b1};
		end
		// Stage validity one edge ahead
		if (mrst) begin
			nxt_ftValid = 1'b0;
		end else if (ftPop) begin
			nxt_ftValid = 1'b1;
		end else if (ftRead) begin
			nxt_ftValid = 1'b0;
		end else begin
			nxt_ftValid = ftValid;
		end
		// Words in the device; the stage word counts only in fall-through
		nxt_total = nxt_memCnt;
		if (nxt_ftMode && nxt_ftValid) begin
			nxt_total = nxt_memCnt + FT_EXTRA;
		end
		// Standard-mode empty and full; held high in the other mode
		nxt_empty_n = nxt_ftMode || (nxt_memCnt != {CW{1'b0}});
		nxt_full_n  = nxt_ftMode || (nxt_memCnt != MEM_DEPTH);
		// Output ready low together with a valid word at the outputs
		nxt_outputReady_n = !(nxt_ftMode && nxt_ftValid);
		// Input ready low in fall-through whenever a free location exists; held high in standard mode
		nxt_inputReady_n = !(nxt_ftMode && (nxt_memCnt != MEM_DEPTH));
		// Almost full: low at (D - m) words or more
		nxt_almostFull_n = (nxt_total < (maxDepth(nxt_ftMode) - widen(fullOffset)));
		// Almost empty: low at n words or less, n+1 in fall-through
		if (nxt_ftMode) begin
			nxt_almostEmpty_n = (nxt_total > (widen(emptyOffset) + FT_EXTRA));
		end else begin
			nxt_almostEmpty_n = (nxt_total > widen(emptyOffset));
		end
		// Half full: low once beyond half the depth; in fall-through, beyond half the memory size plus one word
		if (nxt_ftMode) begin
			nxt_halfFull_n = !(nxt_total > (((maxDepth(1'b1) - FT_EXTRA) >> 1) + FT_EXTRA));
		end else begin
			nxt_halfFull_n = !(nxt_total > (maxDepth(1'b0) >> 1));
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pointers, counts, standard output word and mode
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr_ff           <= {AW{1'b0}};
			rdPtr_ff           <= {AW{1'b0}};
			memCnt_ff          <= {CW{1'b0}};
			stdData_ff         <= {WIDTH{1'b0}};
			fallThroughMode_ff <= 1'b0;
		end else if (ce) begin
			// Mode is caught while master reset is held; chains need it set
			fallThroughMode_ff <= nxt_ftMode;
			memCnt_ff          <= nxt_memCnt;
			if (mrst) begin
				wrPtr_ff <= {AW{1'b0}};
				rdPtr_ff <= {AW{1'b0}};
			end else begin
				if (wrOk) begin
					wrPtr_ff <= wrPtr_ff + {{(AW-1){1'b0}}, 1'b1};
				end
				if (pop) begin
					rdPtr_ff <= rdPtr_ff + {{(AW-1){1'b0}}, 1'b1};
				end
			end
			// Standard read presents the word after the read edge
			if (stdPop) begin
				stdData_ff <= memRdData;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Flag registers
	// All flags share the one clock, so the almost-full flag moves only on
	// the write edge by construction.
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			empty_n_ff       <= `FFC_RST_EMPTY_N;
			full_n_ff        <= `FFC_RST_FULL_N;
			outputReady_n_ff <= `FFC_RST_OREADY_N;
			inputReady_n_ff  <= `FFC_RST_IREADY_N;
			almostFull_n_ff  <= `FFC_RST_AFULL_N;
			almostEmpty_n_ff <= `FFC_RST_AEMPTY_N;
			halfFull_n_ff    <= `FFC_RST_HFULL_N;
		end else if (ce) begin
			empty_n_ff       <= nxt_empty_n;
			full_n_ff        <= nxt_full_n;
			outputReady_n_ff <= nxt_outputReady_n;
			inputReady_n_ff  <= nxt_inputReady_n;
			almostFull_n_ff  <= nxt_almostFull_n;
			almostEmpty_n_ff <= nxt_almostEmpty_n;
			halfFull_n_ff    <= nxt_halfFull_n;
		end
	end

endmodule // ffc_fifo_top

`default_nettype wire

/* File: core/ffc_out_stage.v */
// Output word register with a valid bit, used as the fall-through stage
`timescale 1ns/1ns
`default_nettype none

module ffc_out_stage #(
	parameter WIDTH = 18
) (
	// Clock, reset and freeze
	input  wire             mclk,
	input  wire             rst_n,
	input  wire             ce,
	// Synchronous clear of the valid bit (master reset)
	input  wire             clear,
	// Load a new word / consume the held word
	input  wire             load,
	input  wire             consume,
	input  wire [WIDTH-1:0] loadData,
	// Held word and its validity
	output reg  [WIDTH-1:0] data_ff,
	output reg              valid_ff
);

	////////////////////////////////////////////////////////////////////////////
	// Data stays after a consume so the last word remains visible
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			data_ff  <= {WIDTH{1'b0}};
			valid_ff <= 1'b0;
		end else if (ce) begin
			if (clear) begin
				// Master reset drops the held word
				valid_ff <= 1'b0;
			end else if (load) begin
				// Refill wins over consume in the same cycle
				data_ff  <= loadData;
				valid_ff <= 1'b1;
			end else if (consume) begin
				valid_ff <= 1'b0;
			end
		end
	end

endmodule // ffc_out_stage

`default_nettype wire

/* File: core/ffc_store.v */
// Flip-flop storage array with one write port and one combinational read port
`timescale 1ns/1ns
`default_nettype none

module ffc_store #(
	parameter WIDTH = 18,
	parameter AW    = 15
) (
	// Clock and freeze
	input  wire             mclk,
	input  wire             ce,
	// Write port
	input  wire             wrStrobe,
	input  wire [AW-1:0]    wrAddr,
	input  wire [WIDTH-1:0] wrData,
	// Read port
	input  wire [AW-1:0]    rdAddr,
	output wire [WIDTH-1:0] rdData
);

	// Word storage, no reset: contents are don't-care until written
	reg [WIDTH-1:0] mem_ff [0:(1<<AW)-1];

	////////////////////////////////////////////////////////////////////////////
	// Write on the rising edge when enabled
	always @(posedge mclk) begin
		if (ce && wrStrobe) begin
			mem_ff[wrAddr] <= wrData;
		end
	end

	// Read is combinational; the caller registers the result
	assign rdData = mem_ff[rdAddr];

endmodule // ffc_store

`default_nettype wire

/* File: shared/ffc_fifo_regs.vh */
// Constants for the flagged FIFO core: depths, widths, flag reset levels and chain timing
`ifndef FFC_FIFO_REGS_VH
`define FFC_FIFO_REGS_VH

// Word width of one device
`define FFC_DATA_WIDTH        18
// Address width of the storage array, 15 gives the smaller organisation
`define FFC_ADDR_WIDTH        15
// Storage sizes of the two organisations, in words
`define FFC_DEPTH_SMALL       32768
`define FFC_DEPTH_LARGE       65536
// Extra word held by the output register in fall-through mode
`define FFC_FT_EXTRA_WORDS    1

// Flag levels right after reset (standard mode, buffer empty)
`define FFC_RST_EMPTY_N       1'b0
`define FFC_RST_FULL_N        1'b1
`define FFC_RST_OREADY_N      1'b1
`define FFC_RST_IREADY_N      1'b1
`define FFC_RST_AFULL_N       1'b1
`define FFC_RST_AEMPTY_N      1'b0
`define FFC_RST_HFULL_N       1'b1

// Bubble-up budget of a full chain: transfer-clock periods per stage, write-clock periods
`define FFC_CHAIN_XFER_CYCLES 3
`define FFC_CHAIN_WR_CYCLES   2

`endif

/* File: sim/ffc_fifo_monitor.sv */
// Checker for flag timing of the FIFO core
`timescale 1ns/1ns
`default_nettype none
module ffc_fifo_monitor #(
	parameter WIDTH = 18,
	parameter AW    = 15
) (
	// Clock, reset and controls
	input wire logic             mclk,
	input wire logic             rst_n,
	input wire logic             ce,
	input wire logic             masterReset_n,
	input wire logic             fallThroughSel,
	input wire logic [AW:0]      fullOffset,
	input wire logic [AW:0]      emptyOffset,
	input wire logic             wrEn_n,
	input wire logic [WIDTH-1:0] dataIn,
	input wire logic             rdEn_n,
	// Outputs under watch
	input wire logic [WIDTH-1:0] dataOut,
	input wire logic             empty_n_ff,
	input wire logic             full_n_ff,
	input wire logic             outputReady_n_ff,
	input wire logic             inputReady_n_ff,
	input wire logic             almostFull_n_ff,
	input wire logic             almostEmpty_n_ff,
	input wire logic             halfFull_n_ff,
	input wire logic             fallThroughMode_ff
);
	// Accepted write and read, refusals on full ignored for writes
	wire takenWr = ce && masterReset_n && !wrEn_n;
	wire takenRd = ce && masterReset_n && !rdEn_n &&
		(fallThroughMode_ff ? !outputReady_n_ff : empty_n_ff);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Write into an empty fall-through buffer, then the word shows
	sequence wrToEmpty;
		fallThroughMode_ff && outputReady_n_ff && takenWr;
	endsequence
	sequence wordShown;
		##[1:2] !outputReady_n_ff;
	endsequence
	afull_idle_a: assert property (masterReset_n && !takenWr && !takenRd |=>
		$stable(almostFull_n_ff) && $stable(almostEmpty_n_ff)) else $error("flag moved idle");
	afull_rise_a: assert property ($rose(almostFull_n_ff) |->
		$past(takenRd || !masterReset_n)) else $error("almost full rose late");
	aempty_rise_a: assert property ($rose(almostEmpty_n_ff) |->
		$past(takenWr)) else $error("almost empty rose late");
	first_word_a: assert property (wrToEmpty |-> wordShown)
		else $error("output ready late");
	free_slot_a: assert property (fallThroughMode_ff && inputReady_n_ff && takenRd && wrEn_n
		|=> !inputReady_n_ff) else $error("input ready late");
	full_set_a: assert property ($fell(full_n_ff) || $rose(inputReady_n_ff) |->
		$past(takenWr || !masterReset_n)) else $error("full without write");
	empty_rise_a: assert property ($rose(empty_n_ff) |->
		$past(takenWr || !masterReset_n)) else $error("empty cleared late");
	mode_held_a: assert property (fallThroughMode_ff ? (empty_n_ff && full_n_ff)
		: (outputReady_n_ff && inputReady_n_ff)) else $error("off-mode flag low");
endmodule // ffc_fifo_monitor
`default_nettype wire

/* File: sim/ffc_fifo_top_tb.sv */
// Testbench for the FIFO core flags and data order
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, a) begin checks_done++; if ((e) !== (a)) begin bad_count++; \
	$display("mismatch %s exp %h got %h", nm, e, a); end end
module ffc_fifo_top_tb;
	localparam WIDTH = 18;
	localparam AW    = 4;
	logic mclk, rst_n, ce, masterReset_n, fallThroughSel, wrEn_n, drainEn, stall;
	logic [AW:0]      fullOffset, emptyOffset;
	// Two paralleled devices form one 36-bit word, low half in device 0
	logic [2*WIDTH-1:0] dataIn, expQ[$];
	wire logic [2*WIDTH-1:0] dataOut;
	wire logic rdEn_n;
	// One flag bit per device, never tied together
	logic [1:0] eN, fN, oN, iN, afN, aeN, hfN, ftM;
	// Composite flags formed through gating
	wire logic eAll = &eN;
	wire logic fAll = &fN;
	wire logic oAny = |oN;
	wire logic iAny = |iN;
	int bad_count, checks_done, cycles;
	logic [31:0] lfsrVal = 32'h05C9;
	// Shared controls and equal depth on both devices
	ffc_fifo_top #(.WIDTH(WIDTH), .AW(AW)) ffc_fifo_top_i [1:0] (.mclk(mclk), .rst_n(rst_n),
		.ce(ce), .masterReset_n(masterReset_n), .fallThroughSel(fallThroughSel),
		.fullOffset(fullOffset), .emptyOffset(emptyOffset), .wrEn_n(wrEn_n), .dataIn(dataIn),
		.rdEn_n(rdEn_n), .dataOut(dataOut), .empty_n_ff(eN), .full_n_ff(fN),
		.outputReady_n_ff(oN), .inputReady_n_ff(iN), .almostFull_n_ff(afN),
		.almostEmpty_n_ff(aeN), .halfFull_n_ff(hfN), .fallThroughMode_ff(ftM));
	ffc_reader_model ffc_reader_model_i (.mclk(mclk), .rst_n(rst_n), .drainEn(drainEn),
		.stall(stall), .rdEn_n(rdEn_n));
	////////////////////////////////////////////////////////////////
	function logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task tick;
		@(posedge mclk);
		#1;
	endtask
	task end_of_test;
		if (bad_count == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Master reset in a mode, fill k words, check flags, drain and compare
	task run(input int ft, input int k);
		int d, m, n, c;
		d = (1 << AW) + ft;
		lfsrVal = lfsr(lfsrVal);
		m = lfsrVal[1:0] + 1;
		n = lfsrVal[3:2] + 1;
		fullOffset = m[AW:0];
		emptyOffset = n[AW:0];
		masterReset_n = 1'b0;
		fallThroughSel = ft[0];
		tick;
		masterReset_n = 1'b1;
		`CHK("mode", {2{ft[0]}}, ftM)
		for (int i = 0; i < k; i++) begin
			lfsrVal = lfsr(lfsrVal);
			wrEn_n = 1'b0;
			dataIn = {lfsrVal[31:32-WIDTH], lfsrVal[WIDTH-1:0]};
			if (i < d) expQ.push_back(dataIn);
			tick;
		end
		wrEn_n = 1'b1;
		// Two cycles of fall-through latency plus one spare for edge spacing
		repeat (3) tick;
		c = (k < d) ? k : d;
		if (ft) begin
			`CHK("outputReady", !(c > 0), oAny)
			`CHK("inputReady", (c >= d), iAny)
		end else begin
			`CHK("empty", (c > 0), eAll)
			`CHK("full", !(c >= d), fAll)
		end
		`CHK("almostFull", {2{!(c >= d - m)}}, afN)
		`CHK("almostEmpty", {2{!(c <= n + ft)}}, aeN)
		`CHK("halfFull", {2{!(c > (ft ? (d - 1) / 2 + 1 : d / 2))}}, hfN)
		// Slow reader with random stalls and clock freezes
		drainEn = 1'b1;
		for (c = 0; c < 80 && expQ.size() > 0; c++) begin
			lfsrVal = lfsr(lfsrVal);
			stall = lfsrVal[0];
			ce = !(lfsrVal[1] && lfsrVal[2]);
			tick;
		end
		drainEn = 1'b0;
		stall = 1'b0;
		ce = 1'b1;
		repeat (3) tick;
		`CHK("left", 0, expQ.size())
		`CHK("drained", 1'b1, ft ? oAny : !eAll)
	endtask
	////////////////////////////////////////////////////////////////
	// Read watcher: pops the oldest note on each accepted read
	always @(posedge mclk) begin : watch
		logic tk, ft;
		logic [2*WIDTH-1:0] w, e;
		// Accepted read judged from composite flags only
		tk = rst_n && ce && masterReset_n && !rdEn_n && (ftM[0] ? !oAny : eAll);
		ft = ftM[0];
		w = dataOut;
		#2;
		if (tk === 1'b1) begin
			if (!ft) w = dataOut;
			if (expQ.size() == 0) `CHK("spare read", 1'b0, 1'b1)
			else begin
				// Popped once here: the compare macro reads its arguments twice
				e = expQ.pop_front();
				`CHK("dataOut", e, w)
			end
		end
		cycles++;
		if (cycles > 10000) begin
			bad_count++;
			end_of_test;
		end
	end
	initial begin
		mclk = 1'b0;
		// One clock serves writer, reader and transfer alike
		forever #5 mclk = ~mclk;
	end
	// Main sequence: both modes, every fill level, then a second reset
	initial begin
		{rst_n, masterReset_n, fallThroughSel, wrEn_n, drainEn, stall} = 6'b010100;
		{ce, fullOffset, emptyOffset, dataIn} = '0;
		ce = 1'b1;
		repeat (10) @(posedge mclk);
		#1 rst_n = 1'b1;
		for (int ft = 0; ft < 2; ft++) begin
			for (int k = 0; k <= (1 << AW) + 1 + ft; k++) run(ft, k);
		end
		rst_n = 1'b0;
		tick;
		`CHK("reset mode", 2'b00, ftM)
		`CHK("reset almostEmpty", 2'b00, aeN)
		// Release again and run a short fall-through pass
		rst_n = 1'b1;
		run(1, 3);
		end_of_test;
	end
endmodule // ffc_fifo_top_tb
bind ffc_fifo_top ffc_fifo_monitor #(.WIDTH(WIDTH), .AW(AW)) ffc_fifo_monitor_i (.mclk(mclk),
	.rst_n(rst_n), .ce(ce), .masterReset_n(masterReset_n), .fallThroughSel(fallThroughSel),
	.fullOffset(fullOffset), .emptyOffset(emptyOffset), .wrEn_n(wrEn_n), .dataIn(dataIn),
	.rdEn_n(rdEn_n), .dataOut(dataOut), .empty_n_ff(empty_n_ff), .full_n_ff(full_n_ff),
	.outputReady_n_ff(outputReady_n_ff), .inputReady_n_ff(inputReady_n_ff),
	.almostFull_n_ff(almostFull_n_ff), .almostEmpty_n_ff(almostEmpty_n_ff),
	.halfFull_n_ff(halfFull_n_ff), .fallThroughMode_ff(fallThroughMode_ff));
`default_nettype wire

/* File: sim/ffc_reader_model.sv */
// Reader logic beside the FIFO core
`timescale 1ns/1ns
`default_nettype none
module ffc_reader_model (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Drain request and stall
	input wire logic drainEn,
	input wire logic stall,
	// Read enable toward the core
	output var logic rdEn_n
);
	// One read a cycle unless stalled; clock never stops
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdEn_n <= 1'b1;
		end else begin
			rdEn_n <= #1 !(drainEn && !stall);
		end
	end
endmodule // ffc_reader_model
`default_nettype wire
